/* common/cmd_addr_pkg.sv */
// Constants and types shared by the command/address controller end and device end.
// Assumes both ends run on one system clock; the memory clock pair is derived from it.
`default_nettype none
package cmd_addr_pkg;
    localparam int ADDR_W = 15;
    localparam int BANK_W = 3;
    localparam int NUM_BANKS = 8;
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    localparam int COL_W = 10;
    // Mode register zero field holding the fixed burst setting and the on-the-fly enable.
    localparam int MR0_BL_LO = 0;
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;
    localparam logic [ADDR_W-1:0] MR_RESET = 15'h0000;
    // Command code {cs_n, ras_n, cas_n, we_n}.
    localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_ACTIVATE = 4'h3;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_ZQ = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_DESELECT = 4'h8;
    typedef enum logic [2:0] {
        OP_NONE, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_MRS
    } op_type;
endpackage
`default_nettype wire

/* common/cmd_addr_if.sv */
// Pin-level link between the memory controller and the device command stage.
// Assumes both ends share CLK_SYS; the clock pair is carried as sampled levels.
`default_nettype none
interface cmd_addr_if;
    logic ck;
    logic ck_c;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [cmd_addr_pkg::ADDR_W-1:0] addr;
    logic [cmd_addr_pkg::BANK_W-1:0] bank;
    logic strobe;
    logic strobe_c;
    modport ctrl (output ck, ck_c, cs_n, ras_n, cas_n, we_n, addr, bank,
                  input strobe, strobe_c);
    modport dev (input ck, ck_c, cs_n, ras_n, cas_n, we_n, addr, bank,
                 output strobe, strobe_c);
endinterface
`default_nettype wire

/* logic/cmd_addr_dev.sv */
// Device end: samples command and address pins at each positive clock crossing and decodes them.
// Assumes the pins arrive from another domain and are synchronised here on CLK_SYS.
// Notes on behaviour
// RULE_01: Activate takes row address for selected bank.
// RULE_02: Read/write take column; bit ten auto-precharge.
// RULE_03: Precharge bit ten: low one bank, high all.
// RULE_04: Load mode takes address as op-code.
// RULE_05: On-the-fly: bit twelve high eight, low four.
// RULE_06: Bank select chooses bank for commands.
// RULE_07: Bank select picks one of four mode registers.
// RULE_08: Sample at true-rise, complement-fall crossing.
// RULE_09: Data strobe pair timed to clock crossings.
// RULE_10: Commands ignored while chip select high.
// RULE_11: Command from strobes, write enable, select.
// RULE_12: Without on-the-fly, bit twelve ignored, use mode.
`default_nettype none
module cmd_addr_dev #(
    parameter int ADDR_W = cmd_addr_pkg::ADDR_W,
    parameter int BANK_W = cmd_addr_pkg::BANK_W
) (
    // System
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Pins
    cmd_addr_if.dev PINS,
    // Data path strobe request
    input wire logic STROBE_EN,
    // Decoded command
    output logic CMD_VALID,
    output cmd_addr_pkg::op_type CMD_OP,
    output logic [BANK_W-1:0] CMD_BANK,
    output logic [ADDR_W-1:0] ROW_ADDR,
    output logic [cmd_addr_pkg::COL_W-1:0] COL_ADDR,
    output logic AUTO_PRECHARGE,
    output logic PRE_ALL,
    output logic FULL_EIGHT_BEAT,
    output logic [1:0] MODE_SEL,
    output logic [ADDR_W-1:0] MODE_OPCODE,
    output logic [cmd_addr_pkg::NUM_BANKS-1:0] BANK_OPEN,
    output logic [ADDR_W-1:0] MODE_REG_ZERO,
    output logic [ADDR_W-1:0] MODE_REG_ONE,
    output logic [ADDR_W-1:0] MODE_REG_TWO,
    output logic [ADDR_W-1:0] MODE_REG_THREE
);
    localparam int SW = 2 + 4 + ADDR_W + BANK_W;
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic ck_prev_r;
    logic [ADDR_W-1:0] mode_r [4];
    logic [1:0] bl_mode;
    logic ck_s, ck_c_s, cs_n_s, ras_n_s, cas_n_s, we_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [BANK_W-1:0] bank_s;
    logic crossing;
    logic [3:0] cmd;
    logic strobe_r;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {PINS.ck, PINS.ck_c, PINS.cs_n, PINS.ras_n, PINS.cas_n, PINS.we_n,
                        PINS.addr, PINS.bank};
            sync2_r <= sync1_r;
        end
    end
    assign {ck_s, ck_c_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, addr_s, bank_s} = sync2_r;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ck_prev_r <= 1'b0;
        end else begin
            ck_prev_r <= ck_s;
        end
    end
    assign crossing = ck_s && !ck_c_s && !ck_prev_r; // RULE_08
    assign cmd = {cs_n_s, ras_n_s, cas_n_s, we_n_s}; // RULE_11
    assign bl_mode = mode_r[0][cmd_addr_pkg::MR0_BL_LO +: 2];

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            CMD_VALID <= 1'b0;
            CMD_OP <= cmd_addr_pkg::OP_NONE;
            CMD_BANK <= '0;
            ROW_ADDR <= '0;
            COL_ADDR <= '0;
            AUTO_PRECHARGE <= 1'b0;
            PRE_ALL <= 1'b0;
            FULL_EIGHT_BEAT <= 1'b1;
            MODE_SEL <= 2'h0;
            MODE_OPCODE <= '0;
        end else begin
            CMD_VALID <= 1'b0;
            CMD_OP <= cmd_addr_pkg::OP_NONE;
            if (crossing && !cs_n_s) begin // RULE_10
                CMD_BANK <= bank_s; // RULE_06
                unique case (cmd)
                    cmd_addr_pkg::CMD_ACTIVATE: begin
                        CMD_VALID <= 1'b1;
                        CMD_OP <= cmd_addr_pkg::OP_ACT;
                        ROW_ADDR <= addr_s; // RULE_01
                    end
                    cmd_addr_pkg::CMD_READ, cmd_addr_pkg::CMD_WRITE: begin
                        CMD_VALID <= 1'b1;
                        CMD_OP <= (cmd == cmd_addr_pkg::CMD_READ) ? cmd_addr_pkg::OP_RD
                                                                  : cmd_addr_pkg::OP_WR;
                        COL_ADDR <= addr_s[cmd_addr_pkg::COL_W-1:0]; // RULE_02
                        AUTO_PRECHARGE <= addr_s[cmd_addr_pkg::AP_BIT]; // RULE_02
                        if (bl_mode == cmd_addr_pkg::BL_OTF) begin
                            FULL_EIGHT_BEAT <= addr_s[cmd_addr_pkg::BC_BIT]; // RULE_05
                        end else begin
                            FULL_EIGHT_BEAT <= (bl_mode != cmd_addr_pkg::BL_FIXED4); // RULE_12
                        end
                    end
                    cmd_addr_pkg::CMD_PRECHARGE: begin
                        CMD_VALID <= 1'b1;
                        CMD_OP <= cmd_addr_pkg::OP_PRE;
                        PRE_ALL <= addr_s[cmd_addr_pkg::AP_BIT]; // RULE_03
                    end
                    cmd_addr_pkg::CMD_LOAD_MODE: begin
                        CMD_VALID <= 1'b1;
                        CMD_OP <= cmd_addr_pkg::OP_MRS;
                        MODE_SEL <= bank_s[1:0]; // RULE_07
                        MODE_OPCODE <= addr_s; // RULE_04
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Mode registers and open-bank tracking follow the decoded commands.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            for (int i = 0; i < 4; i++) begin
                mode_r[i] <= cmd_addr_pkg::MR_RESET;
            end
        end else if (crossing && cmd == cmd_addr_pkg::CMD_LOAD_MODE) begin
            mode_r[bank_s[1:0]] <= addr_s; // RULE_07
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            BANK_OPEN <= '0;
        end else if (crossing && !cs_n_s) begin
            if (cmd == cmd_addr_pkg::CMD_ACTIVATE) begin
                BANK_OPEN[bank_s] <= 1'b1; // RULE_06
            end else if (cmd == cmd_addr_pkg::CMD_PRECHARGE) begin
                if (addr_s[cmd_addr_pkg::AP_BIT]) begin
                    BANK_OPEN <= '0; // RULE_03
                end else begin
                    BANK_OPEN[bank_s] <= 1'b0; // RULE_03
                end
            end
        end
    end

    // The strobe pair toggles on each sampled crossing while the data path asks for it.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            strobe_r <= 1'b0;
        end else if (STROBE_EN && crossing) begin
            strobe_r <= ~strobe_r; // RULE_09
        end else if (!STROBE_EN) begin
            strobe_r <= 1'b0;
        end
    end
    assign PINS.strobe = strobe_r;
    assign PINS.strobe_c = ~strobe_r;

    assign MODE_REG_ZERO = mode_r[0];
    assign MODE_REG_ONE = mode_r[1];
    assign MODE_REG_TWO = mode_r[2];
    assign MODE_REG_THREE = mode_r[3];
endmodule // cmd_addr_dev
`default_nettype wire

/* logic/cmd_addr_ctrl.sv */
// Controller end: encodes one requested command onto the pins and drives the clock pair.
// Assumes requests come from logic on CLK_SYS; the clock pair is CLK_SYS divided by HALF_PERIOD*2.
`default_nettype none
module cmd_addr_ctrl #(
    parameter int ADDR_W = cmd_addr_pkg::ADDR_W,
    parameter int BANK_W = cmd_addr_pkg::BANK_W,
    parameter int HALF_PERIOD = 4
) (
    // System
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Request
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic [3:0] REQ_CMD,
    input wire logic [BANK_W-1:0] REQ_BANK,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    // Pins
    cmd_addr_if.ctrl PINS
);
    logic [7:0] div_r;
    logic ck_r;
    logic [3:0] cmd_r;
    logic [ADDR_W-1:0] addr_r;
    logic [BANK_W-1:0] bank_r;
    logic fall;

    assign fall = ck_r && (div_r == 8'(HALF_PERIOD - 1));

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            div_r <= 8'h00;
            ck_r <= 1'b0;
        end else if (div_r == 8'(HALF_PERIOD - 1)) begin
            div_r <= 8'h00;
            ck_r <= ~ck_r;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // Pins change at the falling clock edge so they stand a half period around the rise.
    assign REQ_READY = fall; // RULE_08
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cmd_r <= cmd_addr_pkg::CMD_DESELECT;
            addr_r <= '0;
            bank_r <= '0;
        end else if (fall) begin
            if (REQ_VALID) begin
                cmd_r <= REQ_CMD; // RULE_11
                addr_r <= REQ_ADDR; // RULE_01
                bank_r <= REQ_BANK;
            end else begin
                cmd_r <= cmd_addr_pkg::CMD_NOP;
            end
        end
    end

    assign PINS.ck = ck_r;
    assign PINS.ck_c = ~ck_r;
    assign {PINS.cs_n, PINS.ras_n, PINS.cas_n, PINS.we_n} = cmd_r;
    assign PINS.addr = addr_r;
    assign PINS.bank = bank_r;
endmodule // cmd_addr_ctrl
`default_nettype wire

/* tb/cmd_addr_properties.sv */
// Checker for the command pins that join the controller end to the device end.
// Assumes the clock pair half period is four system cycles.
`default_nettype none
module cmd_addr_properties (
    // System
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Pins
    input wire logic ck,
    input wire logic ck_c,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [cmd_addr_pkg::ADDR_W-1:0] addr,
    input wire logic [cmd_addr_pkg::BANK_W-1:0] bank,
    input wire logic strobe,
    input wire logic strobe_c
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic [21:0] pins;
    assign pins = {cs_n, ras_n, cas_n, we_n, addr, bank};
    chk_ck_pair: assert property (ck_c == !ck)
        else $error("clock pair not complementary");
    chk_hold_at_rise: assert property ($rose(ck) |-> $stable(pins) ##1 $stable(pins)[*2])
        else $error("pins move around the rising crossing");
    chk_change_low: assert property ($changed(pins) |-> !ck)
        else $error("pins change while clock is high");
    chk_ck_high_len: assert property ($rose(ck) |-> ck[*4] ##1 !ck)
        else $error("clock high phase length wrong");
    chk_ck_low_len: assert property ($fell(ck) |-> !ck[*4] ##1 ck)
        else $error("clock low phase length wrong");
    chk_one_cmd_period: assert property ($changed(pins) |=> $stable(pins)[*7])
        else $error("command changed within one clock period");
    chk_strobe_pair: assert property (strobe_c == !strobe)
        else $error("strobe pair not complementary");
    chk_strobe_rise_high: assert property ($rose(strobe) |-> ck)
        else $error("strobe rose outside the clock high phase");
    chk_reset_idle: assert property (disable iff (1'b0) !RST_N |=> cs_n && !ck && !strobe)
        else $error("pins not idle during reset");
    cover property ($rose(ck) && !cs_n && !ras_n && cas_n && we_n);
    cover property ($rose(ck) && !cs_n && ras_n && !cas_n && we_n);
    cover property ($rose(ck) && !cs_n && !ras_n && !cas_n && !we_n);
    cover property ($rose(strobe));
endmodule // cmd_addr_properties
`default_nettype wire

/* tb/sdram_cmd_addr_decode_bench.sv */
// Bench joining the controller end to the device end, checking the decoded commands.
// Assumes the package, interface, both ends and the checker are compiled first.
`default_nettype none
module sdram_cmd_addr_decode_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic [3:0] req_cmd = 4'h7;
    logic [2:0] req_bank = 3'h0;
    logic [14:0] req_addr = 15'h0000;
    logic strobe_en = 1'b0;
    logic req_ready, cmd_valid, auto_pre, pre_all, full_eight;
    cmd_addr_pkg::op_type cmd_op;
    logic [2:0] cmd_bank;
    logic [14:0] row_addr, mode_opcode;
    logic [9:0] col_addr;
    logic [1:0] mode_sel;
    logic [7:0] bank_open;
    logic [3:0][14:0] mreg;
    logic [3:0][14:0] mexp = '0;
    logic [7:0] bexp = 8'h00;
    int mismatches = 0;
    int n_compared = 0;
    int seed = 13;
    // Last entry is an activate sent with chip select high.
    logic [3:0] cmds [6] = '{4'h3, 4'h5, 4'h4, 4'h2, 4'h0, 4'hb};
    cmd_addr_pkg::op_type ops [6] = '{cmd_addr_pkg::OP_ACT, cmd_addr_pkg::OP_RD,
        cmd_addr_pkg::OP_WR, cmd_addr_pkg::OP_PRE, cmd_addr_pkg::OP_MRS, cmd_addr_pkg::OP_NONE};
    always #25 clk_sys = ~clk_sys;
    cmd_addr_if bus ();
    cmd_addr_ctrl cmd_addr_ctrl_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ_CMD(req_cmd), .REQ_BANK(req_bank), .REQ_ADDR(req_addr),
        .PINS(bus));
    cmd_addr_dev cmd_addr_dev_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .PINS(bus),
        .STROBE_EN(strobe_en), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_BANK(cmd_bank),
        .ROW_ADDR(row_addr), .COL_ADDR(col_addr), .AUTO_PRECHARGE(auto_pre), .PRE_ALL(pre_all),
        .FULL_EIGHT_BEAT(full_eight), .MODE_SEL(mode_sel), .MODE_OPCODE(mode_opcode),
        .BANK_OPEN(bank_open), .MODE_REG_ZERO(mreg[0]), .MODE_REG_ONE(mreg[1]),
        .MODE_REG_TWO(mreg[2]), .MODE_REG_THREE(mreg[3]));
    cmd_addr_properties cmd_addr_properties_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .ck(bus.ck),
        .ck_c(bus.ck_c), .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n),
        .addr(bus.addr), .bank(bus.bank), .strobe(bus.strobe), .strobe_c(bus.strobe_c));
    function automatic logic exp_eight(input logic [14:0] a);
        case (mexp[0][1:0])
            2'h1: return a[12];
            2'h2: return 1'b0;
            default: return 1'b1;
        endcase
    endfunction
    task automatic check(input logic ok);
        n_compared++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("MISMATCH %0t decoded output differs", $time);
        end
    endtask
    task automatic end_sim;
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic issue(input int k, input logic [2:0] b, input logic [14:0] a);
        int n;
        n = 0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_cmd <= cmds[k];
        req_bank <= b;
        req_addr <= a;
        strobe_en <= ~strobe_en;
        @(negedge clk_sys);
        while (req_ready !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        while (!(cmd_valid === 1'b1 && cmd_op !== cmd_addr_pkg::OP_NONE) && n < 24) begin
            @(negedge clk_sys);
            n++;
        end
        check(k == 5 ? n == 24 : cmd_op === ops[k]);
        if (k == 0) begin
            bexp[b] = 1'b1;
        end else if (k == 3) begin
            bexp[b] = 1'b0;
            if (a[10]) begin
                bexp = 8'h00;
            end
        end
        check(bank_open === bexp);
        check(strobe_en || (bus.strobe === 1'b0 && bus.strobe_c === 1'b1));
        case (k)
            0: check(row_addr === a && cmd_bank === b && bank_open[b] === 1'b1);
            3: begin
                check(pre_all === a[10] && cmd_bank === b);
                check(a[10] ? bank_open === 8'h00 : bank_open[b] === 1'b0);
            end
            4: begin
                mexp[b[1:0]] = a;
                check(mode_sel === b[1:0] && mode_opcode === a && mreg === mexp);
            end
            5: check(mreg === mexp);
            default: begin
                check(col_addr === a[9:0] && auto_pre === a[10] && cmd_bank === b);
                check(full_eight === exp_eight(a));
            end
        endcase
    endtask
    initial begin
        logic [31:0] r;
        logic [31:0] q;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        check(mreg === mexp && full_eight === 1'b1 && bank_open === 8'h00);
        for (int m = 0; m < 8; m++) begin
            issue(4, 3'h0, {13'h0000, m[2:1]});
            issue(1, 3'h7, {2'h0, m[0], 12'h400});
        end
        for (int i = 0; i < 90; i++) begin
            r = $random(seed);
            q = $random(seed);
            issue(int'(r[7:0] % 8'd6), r[10:8], q[14:0]);
        end
        end_sim;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        end_sim;
    end
endmodule // sdram_cmd_addr_decode_bench
`default_nettype wire
